// ===== test/osp_chk.sv
// Assertion checker for the option slot presence link
`default_nettype none
module osp_chk
(
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  arst_n,
  // Images
  input wire osp_pkg::osp_word_type outputImage,
  input wire osp_pkg::osp_word_type inputImage,
  // Device pins
  input wire logic                  optionEnable,
  input wire logic                  withoutReserve,
  input wire logic                  optionEntry,
  input wire logic                  ioActive,
  input wire logic                  systemFault,
  input wire logic                  busFault,
  input wire osp_pkg::osp_byte_type diagStatus1,
  input wire osp_pkg::osp_byte_type diagIdHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  import osp_pkg::*;
  logic validSeen_reg;
  logic firstWait_reg;
  wire  optOn   = optionEnable && withoutReserve && optionEntry;
  wire  validIn = optionEntry && outputImage[0];

  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Helper flags
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      validSeen_reg <= 1'b0;
    else if (validIn)
      validSeen_reg <= 1'b1;

  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      firstWait_reg <= 1'b1;
    else if (validIn || !optOn)
      firstWait_reg <= 1'b0;

  sequence validHeld;
    (validIn && $stable(outputImage)) [*3];
  endsequence

  sequence noValid;
    !validSeen_reg [*3];
  endsequence

  // ==========================================================
  // Properties
  entry_off_a: assert property (
    !optionEntry [*3] |-> inputImage == 64'h0)
    else $error("feedback not cleared without entry");
  active_bit_a: assert property (
    optOn [*3] |-> inputImage[0])
    else $error("active bit low");
  no_slots_a: assert property (
    noValid |-> inputImage[63:1] == 63'h0)
    else $error("slot bits before valid info");
  slot_subset_a: assert property (
    validHeld |-> (inputImage[63:1] & ~outputImage[63:1]) == 63'h0)
    else $error("unrequested slot reported");
  wait_quiet_a: assert property (
    firstWait_reg && optOn |-> !ioActive && !busFault && !systemFault)
    else $error("activity while waiting for info");
  overflow_flags_a: assert property (
    diagIdHigh[7] |-> diagStatus1[3] && systemFault)
    else $error("overflow flags disagree");
  match_io_a: assert property (
    (validIn && inputImage == outputImage && !diagIdHigh[7]) [*3]
      |-> ioActive)
    else $error("I/O off despite match");
  nostart_io_a: assert property (
    systemFault && !diagIdHigh[7] |-> !ioActive)
    else $error("I/O on after failed start");
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the option slot presence link
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import osp_pkg::*;
  localparam osp_word_type FULL = 64'h8000_0000_0000_0103;
  logic         clock = 1'b0, arst_n = 1'b0;
  logic         optionEnable = 1'b1, withoutReserve = 1'b1;
  logic         optionEntry = 1'b1, mismatchAllowed = 1'b0;
  logic         warmRestart = 1'b0, linkError = 1'b1;
  logic         reqValid = 1'b0, reqBlock = 1'b0;
  osp_word_type reqWord = 64'h0, slotPresent = 64'h102, slotGood = ~64'h0;
  logic         ioActive, systemFault, busFault, diagNoModule;
  logic         diagWrongModule, reqReady, configOk;
  osp_byte_type diagStatus1, diagIdHigh;
  osp_word_type moduleFault, feedbackWord;
  int           failCount = 0, numChecks = 0, cycles = 0;

  // ==========================================================
  // Clock, link and both ends
  always #5 clock = ~clock;
  osp_link_if link (.clock, .arst_n);
  osp_device i_osp_device (.link, .optionEnable, .withoutReserve,
    .optionEntry, .mismatchAllowed, .warmRestart, .linkError,
    .slotPresent, .slotGood, .ioActive, .systemFault, .busFault,
    .diagNoModule, .diagWrongModule, .diagStatus1, .diagIdHigh,
    .moduleFault);
  osp_master i_osp_master (.link, .reqValid, .reqBlock, .reqWord,
    .reqReady, .feedbackWord, .configOk);
  osp_chk i_osp_chk (.clock, .arst_n, .outputImage(link.outputImage),
    .inputImage(link.inputImage), .optionEnable, .withoutReserve,
    .optionEntry, .ioActive, .systemFault, .busFault, .diagStatus1,
    .diagIdHigh);

  // ==========================================================
  // Shared tasks
  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    numChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic send(osp_word_type w, logic blk);
    osp_byte_type lo;
    int n;
    lo = blk ? {w[7:1], 1'b0} : link.outputImage[7:0];
    n = 0;
    reqWord = w;
    reqBlock = blk;
    reqValid = 1'b1;
    cyc(1);
    reqValid = 1'b0;
    do
    begin
      if (reqReady !== 1'b1)
        chk("first byte", lo, link.outputImage[7:0]);
      cyc(1);
      n++;
    end
    while (reqReady !== 1'b1 && n < 12);
    chk("ready", 64'h1, reqReady);
    chk("image", w, link.outputImage);
    cyc(4);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_first;
    cyc(4);
    chk("io", 64'h0, ioActive);
    chk("faults", 64'h0, {systemFault, busFault});
    chk("active bit", 64'h1, feedbackWord[0]);
    chk("slots", 64'h0, feedbackWord[63:1]);
    $display("done: first start");
  endtask

  task automatic t_missing;
    send(FULL, 1'b0);
    chk("sys fault", 64'h1, systemFault);
    chk("no module", 64'h1, diagNoModule);
    chk("module led", 64'h8000_0000_0000_0000, moduleFault);
    chk("io", 64'h0, ioActive);
    chk("feedback", 64'h103, feedbackWord);
    chk("ok", 64'h0, configOk);
    slotPresent = FULL;
    cyc(4);
    chk("io", 64'h1, ioActive);
    chk("ok", 64'h1, configOk);
    chk("fault", 64'h0, systemFault);
    chk("bus fault", 64'h1, busFault);
    linkError = 1'b0;
    $display("done: missing module");
  endtask

  task automatic t_block;
    send(64'h8000_0100_0000_0102, 1'b1);
    chk("kept", FULL, feedbackWord);
    send(64'h8000_0000_0000_0003, 1'b1);
    chk("feedback", 64'h8000_0000_0000_0003, feedbackWord);
    chk("sys fault", 64'h1, systemFault);
    chk("id high", 64'h80, diagIdHigh);
    chk("ext diag", 64'h08, diagStatus1);
    send(FULL, 1'b0);
    chk("overflow", 64'h0, diagIdHigh[7]);
    $display("done: block write");
  endtask

  task automatic t_warm;
    mismatchAllowed = 1'b1;
    slotGood[8] = 1'b0;
    warmRestart = 1'b1;
    cyc(1);
    warmRestart = 1'b0;
    chk("io", 64'h1, ioActive);
    cyc(4);
    chk("io", 64'h0, ioActive);
    chk("slot 8", 64'h0, feedbackWord[8]);
    slotGood[8] = 1'b1;
    cyc(4);
    chk("io", 64'h1, ioActive);
    $display("done: warm restart");
  endtask

  task automatic t_opt;
    for (int i = 0; i < 2; i++)
    begin
      {optionEnable, withoutReserve} = i ? 2'b01 : 2'b10;
      cyc(4);
      chk("active bit", 64'h0, feedbackWord[0]);
      chk("io", 64'h1, ioActive);
    end
    {optionEnable, withoutReserve} = 2'b11;
    optionEntry = 1'b0;
    cyc(4);
    chk("image", 64'h0, feedbackWord);
    optionEntry = 1'b1;
    cyc(4);
    $display("done: option off");
  endtask

  task automatic t_wrong;
    arst_n = 1'b0;
    mismatchAllowed = 1'b0;
    slotGood[8] = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    send(FULL, 1'b1);
    chk("wrong", 64'h1, diagWrongModule);
    chk("no module", 64'h0, diagNoModule);
    chk("faults", 64'h0, {systemFault, ioActive});
    $display("done: wrong module");
  endtask

  // ==========================================================
  // Run control
  task automatic finish_test;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failCount++;
      finish_test();
    end
  end

  initial
  begin
    cyc(6);
    arst_n = 1'b1;
    t_first();
    t_missing();
    t_block();
    t_warm();
    t_opt();
    t_wrong();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== verilog/osp_consts.svh
// Constants for the option slot presence check
`ifndef OSP_CONSTS_SVH
`define OSP_CONSTS_SVH

// =============================================================
// Image layout
`define OSP_WORD_BITS     64
`define OSP_IMAGE_BYTES   8
`define OSP_BYTE_BITS     8
`define OSP_LAST_BYTE_IDX 3'h7
`define OSP_VALID_BIT     0
`define OSP_ACTIVE_BIT    0
`define OSP_MAX_SLOT      63

// =============================================================
// Diagnostics layout
`define OSP_STAT1_EXTDIAG_BIT 3
`define OSP_IDDIAG_HIGH_BIT   7

// =============================================================
// Reset values
`define OSP_WORD_RST  64'h0000_0000_0000_0000
`define OSP_BYTE_RST  8'h00
`define OSP_COUNT_RST 7'h00

`endif

// ===== verilog/osp_device.sv
// Device end: slot presence check and I/O activation gating
`include "osp_consts.svh"
`default_nettype none

module osp_device
(
  // Link
  osp_link_if.device                link,
  // Station parameters
  input  wire logic                 optionEnable,
  input  wire logic                 withoutReserve,
  input  wire logic                 optionEntry,
  input  wire logic                 mismatchAllowed,
  // Restart and bus
  input  wire logic                 warmRestart,
  input  wire logic                 linkError,
  // Actual station
  input  wire osp_pkg::osp_word_type slotPresent,
  input  wire osp_pkg::osp_word_type slotGood,
  // Status
  output logic                      ioActive,
  output logic                      systemFault,
  output logic                      busFault,
  output logic                      diagNoModule,
  output logic                      diagWrongModule,
  output osp_pkg::osp_byte_type     diagStatus1,
  output osp_pkg::osp_byte_type     diagIdHigh,
  output osp_pkg::osp_word_type     moduleFault
);
  import osp_pkg::*;

  // =============================================================
  // Helpers
  function automatic logic [6:0] countOnes(input osp_word_type w);
    logic [6:0] n;
    n = `OSP_COUNT_RST;
    for (int i = 1; i <= `OSP_MAX_SLOT; i++)
    begin
      n = n + {6'h00, w[i]};
    end
    return n;
  endfunction

  // =============================================================
  // Registers
  osp_word_type      ctrl_reg;
  osp_word_type      retained_reg;
  logic              retainedValid_reg;
  logic              fromWarm_reg;
  osp_dev_state_type state_reg;
  osp_dev_state_type state_next;
  osp_word_type      feedback_reg;
  logic              ioActive_reg;
  logic              systemFault_reg;
  logic              busFault_reg;
  logic              diagNoModule_reg;
  logic              diagWrongModule_reg;
  osp_byte_type      diagStatus1_reg;
  osp_byte_type      diagIdHigh_reg;
  osp_word_type      moduleFault_reg;

  // =============================================================
  // Decode
  wire logic         reachable;
  wire logic         optActive;
  wire logic         ctrlChanged;
  wire logic         infoValid;
  wire osp_word_type expected;
  wire osp_word_type feedbackNow;
  wire logic         slotsMatch;
  wire logic         missing;
  wire logic         wrong;
  wire logic         overflow;
  wire logic         failedStart;

  assign reachable   = optionEntry;
  assign optActive   = optionEnable && withoutReserve && reachable;
  assign ctrlChanged = reachable && (link.outputImage != ctrl_reg);
  assign infoValid   = ctrl_reg[`OSP_VALID_BIT];
  assign expected    = infoValid ? ctrl_reg : retained_reg;
  assign feedbackNow = {expected[63:1] & slotPresent[63:1] & slotGood[63:1],
                        optActive};
  assign slotsMatch  = (feedbackNow[63:1] == expected[63:1]);
  assign missing     = |(expected[63:1] & ~slotPresent[63:1]);
  assign wrong       = |(expected[63:1] & slotPresent[63:1] & ~slotGood[63:1]);
  assign overflow    = optActive && (infoValid || retainedValid_reg) &&
                       (countOnes(slotPresent) > countOnes(expected));
  assign failedStart = (state_reg == ST_NOSTART);

  // =============================================================
  // Sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT:
      begin
        if (!optActive)
          state_next = ST_RUN;
        else if (infoValid)
        begin
          if (slotsMatch || mismatchAllowed)
            state_next = ST_RUN;
          else if (missing)
            state_next = ST_NOSTART;
          else
            state_next = ST_HOLD;
        end
      end
      ST_RUN:
      begin
        if (optActive && !slotsMatch && fromWarm_reg)
          state_next = ST_HOLD;
        else if (optActive && !slotsMatch && !mismatchAllowed)
          state_next = missing ? ST_NOSTART : ST_HOLD;
      end
      ST_HOLD, ST_NOSTART:
      begin
        if (!optActive || slotsMatch)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_WAIT;
    endcase
    if (warmRestart)
      state_next = retainedValid_reg ? ST_RUN : ST_WAIT;
  end

  always_ff @(posedge link.clock or negedge link.arst_n)
  begin
    if (!link.arst_n)
    begin
      ctrl_reg          <= `OSP_WORD_RST;
      retained_reg      <= `OSP_WORD_RST;
      retainedValid_reg <= 1'b0;
      fromWarm_reg      <= 1'b0;
      state_reg         <= ST_WAIT;
    end
    else
    begin
      if (ctrlChanged)
        ctrl_reg <= link.outputImage;
      if (optActive && infoValid)
      begin
        retained_reg      <= ctrl_reg;
        retainedValid_reg <= 1'b1;
      end
      if (warmRestart)
        fromWarm_reg <= retainedValid_reg;
      else if (slotsMatch || !optActive)
        fromWarm_reg <= 1'b0;
      state_reg <= state_next;
    end
  end

  // =============================================================
  // Outputs
  always_ff @(posedge link.clock or negedge link.arst_n)
  begin
    if (!link.arst_n)
    begin
      feedback_reg        <= `OSP_WORD_RST;
      ioActive_reg        <= 1'b0;
      systemFault_reg     <= 1'b0;
      busFault_reg        <= 1'b0;
      diagNoModule_reg    <= 1'b0;
      diagWrongModule_reg <= 1'b0;
      diagStatus1_reg     <= `OSP_BYTE_RST;
      diagIdHigh_reg      <= `OSP_BYTE_RST;
      moduleFault_reg     <= `OSP_WORD_RST;
    end
    else
    begin
      feedback_reg <= reachable ? feedbackNow : `OSP_WORD_RST;
      ioActive_reg <= (state_next == ST_RUN);
      systemFault_reg <= (state_next == ST_NOSTART) || overflow;
      busFault_reg <= linkError && (state_next != ST_WAIT);
      diagNoModule_reg <= optActive && infoValid && missing &&
                          !mismatchAllowed;
      diagWrongModule_reg <= optActive && infoValid && wrong &&
                             !mismatchAllowed;
      diagStatus1_reg <= overflow ? (8'h01 << `OSP_STAT1_EXTDIAG_BIT)
                                  : `OSP_BYTE_RST;
      diagIdHigh_reg <= overflow ? (8'h01 << `OSP_IDDIAG_HIGH_BIT)
                                 : `OSP_BYTE_RST;
      moduleFault_reg <= failedStart ? (expected & ~feedbackNow &
                                        64'hFFFF_FFFF_FFFF_FFFE)
                                     : `OSP_WORD_RST;
    end
  end

  assign link.inputImage = feedback_reg;
  assign ioActive        = ioActive_reg;
  assign systemFault     = systemFault_reg;
  assign busFault        = busFault_reg;
  assign diagNoModule    = diagNoModule_reg;
  assign diagWrongModule = diagWrongModule_reg;
  assign diagStatus1     = diagStatus1_reg;
  assign diagIdHigh      = diagIdHigh_reg;
  assign moduleFault     = moduleFault_reg;

endmodule
`default_nettype wire

// ===== verilog/osp_link_if.sv
// Process image link between master and device
`default_nettype none
interface osp_link_if
(
  input wire logic clock,
  input wire logic arst_n
);
  import osp_pkg::*;

  osp_word_type outputImage;
  osp_word_type inputImage;

  modport device
  (
    input  clock,
    input  arst_n,
    input  outputImage,
    output inputImage
  );

  modport master
  (
    input  clock,
    input  arst_n,
    output outputImage,
    input  inputImage
  );
endinterface
`default_nettype wire

// ===== verilog/osp_master.sv
// Master end: writes the control image and checks the feedback
`include "osp_consts.svh"
`default_nettype none
module osp_master
(
  // Link
  osp_link_if.master                link,
  // Request
  input  wire logic                 reqValid,
  input  wire logic                 reqBlock,
  input  wire osp_pkg::osp_word_type reqWord,
  output logic                      reqReady,
  // Result
  output osp_pkg::osp_word_type     feedbackWord,
  output logic                      configOk
);
  import osp_pkg::*;

  // =============================================================
  // Registers
  osp_host_state_type state_reg;
  osp_word_type       pending_reg;
  osp_word_type       image_reg;
  logic [2:0]         byteIdx_reg;
  logic               reqReady_reg;
  osp_word_type       feedback_reg;
  logic               configOk_reg;

  wire logic         take;
  wire osp_word_type byteMask;

  assign take     = reqValid && (state_reg == HS_IDLE);
  assign byteMask = 64'h0000_0000_0000_00FF << {byteIdx_reg, 3'h0};

  always_ff @(posedge link.clock or negedge link.arst_n)
  begin
    if (!link.arst_n)
    begin
      state_reg    <= HS_IDLE;
      pending_reg  <= `OSP_WORD_RST;
      image_reg    <= `OSP_WORD_RST;
      byteIdx_reg  <= `OSP_LAST_BYTE_IDX;
      reqReady_reg <= 1'b0;
      feedback_reg <= `OSP_WORD_RST;
      configOk_reg <= 1'b0;
    end
    else
    begin
      feedback_reg <= link.inputImage;
      configOk_reg <= (link.inputImage == image_reg);
      case (state_reg)
        HS_IDLE:
        begin
          reqReady_reg <= 1'b0;
          if (take)
          begin
            pending_reg <= reqWord;
            byteIdx_reg <= `OSP_LAST_BYTE_IDX;
            if (reqBlock)
            begin
              image_reg <= reqWord & 64'hFFFF_FFFF_FFFF_FFFE;
              state_reg <= HS_ARM;
            end
            else
              state_reg <= HS_BYTES;
          end
        end
        HS_BYTES:
        begin
          image_reg <= (image_reg & ~byteMask) | (pending_reg & byteMask);
          byteIdx_reg <= byteIdx_reg - 3'h1;
          if (byteIdx_reg == 3'h0)
          begin
            state_reg    <= HS_IDLE;
            reqReady_reg <= 1'b1;
          end
        end
        HS_ARM:
        begin
          image_reg[`OSP_VALID_BIT] <= pending_reg[`OSP_VALID_BIT];
          state_reg    <= HS_IDLE;
          reqReady_reg <= 1'b1;
        end
        default:
          state_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.outputImage = image_reg;
  assign reqReady         = reqReady_reg;
  assign feedbackWord     = feedback_reg;
  assign configOk         = configOk_reg;

endmodule
`default_nettype wire

// ===== verilog/osp_pkg.sv
// Types shared by both ends of the option slot presence check
`default_nettype none
package osp_pkg;

  typedef logic [63:0] osp_word_type;
  typedef logic [7:0]  osp_byte_type;

  typedef enum logic [1:0]
  {
    ST_WAIT    = 2'b00,
    ST_RUN     = 2'b01,
    ST_HOLD    = 2'b10,
    ST_NOSTART = 2'b11
  } osp_dev_state_type;

  typedef enum logic [1:0]
  {
    HS_IDLE  = 2'b00,
    HS_BYTES = 2'b01,
    HS_ARM   = 2'b10
  } osp_host_state_type;

endpackage
`default_nettype wire
